// *** dv/tmc_pin_model.sv ***
// external clock and capture sources for the four timers
`timescale 1ns/100ps
module tmc_pin_model (
  input  wire logic       clk_sys_in,
  output logic      [3:0] clk_pins_out,
  output logic      [3:0] cap_pins_out
);
  // pin sharing taken as already set to timer use
  initial begin
    clk_pins_out = 4'h0;
    cap_pins_out = 4'h0;
  end
  // each high level held 3 cycles and each low level at least 3 so the core never misses an edge
  task pulse(input bit cap, input int ch, input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      if (cap) cap_pins_out[ch] <= 1'b1;
      else clk_pins_out[ch] <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      if (cap) cap_pins_out[ch] <= 1'b0;
      else clk_pins_out[ch] <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
    end
  endtask
endmodule

// *** dv/tmc_top_assertions.sv ***
// concurrent checks on the timer core register bus and output pins
`timescale 1ns/100ps
module tmc_top_assertions (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        s_axi_awvalid_in,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic        s_axi_awready_out,
  input  wire logic        s_axi_wready_out,
  input  wire logic [1:0]  s_axi_bresp_out,
  input  wire logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic        s_axi_arready_out,
  input  wire logic [31:0] s_axi_rdata_out,
  input  wire logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [3:0]  timer_output_pin_out,
  input  wire logic [1:0]  timer_output_inverted_pin_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  a_aw_w_pair: assert property (s_axi_awready_out == s_axi_wready_out)
    else $error("address and data ready differ");
  a_write_take: assert property (s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out
    |-> ##[0:2] s_axi_awready_out) else $error("write not taken in time");
  a_write_answer: assert property (s_axi_awready_out |=> s_axi_bvalid_out)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_no_aw_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_byte_data: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  a_inv_pins: assert property (timer_output_inverted_pin_out == ~timer_output_pin_out[1:0])
    else $error("inverted pin not complement");
endmodule

bind tmc_top tmc_top_assertions u_chk (.clk_sys_in, .rst_b_in, .s_axi_awvalid_in,
  .s_axi_wvalid_in, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .timer_output_pin_out, .timer_output_inverted_pin_out);

// *** dv/tmc_top_tb_top.sv ***
// self-checking bench for the timer core
`timescale 1ns/100ps
module tmc_top_tb_top;
  import tmc_pkg::*;
  logic        clk_sys_in, rst_b_in, irq_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in, timer_clock_pin_in, capture_input_pin_in, timer_output_pin_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, timer_output_inverted_pin_out;
  int          bad_count, checks;

  tmc_top u_dut (.clk_sys_in, .rst_b_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .timer_clock_pin_in, .capture_input_pin_in, .timer_output_pin_out,
    .timer_output_inverted_pin_out, .irq_out);
  tmc_pin_model u_pins (.clk_sys_in, .clk_pins_out(timer_clock_pin_in),
    .cap_pins_out(capture_input_pin_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait so a silent slave cannot hang the run
  task automatic wait_hi(ref logic s);
    repeat (50) begin
      @(posedge clk_sys_in);
      if (s === 1'b1) return;
    end
    chk(32'h0, 32'h1);
  endtask

  function automatic logic [7:0] ad(input int t, input logic [2:0] r);
    return 8'(t * 32 + 4 * int'(r));
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    wait_hi(s_axi_awready_out);
    s_axi_awvalid_in <= 1'b0;
    s_axi_wvalid_in <= 1'b0;
    wait_hi(s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
    chk(32'(s_axi_bresp_out), 32'(rsp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] rsp);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    wait_hi(s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    wait_hi(s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rdata_out, {24'h000000, exp});
    chk(32'(s_axi_rresp_out), 32'(rsp));
  endtask

  task automatic test_reset();
    chk({irq_out, timer_output_pin_out, timer_output_inverted_pin_out}, 32'h03);
    rd(ad(0, REG_CTRL0), 8'h00, RESP_OKAY);
    rd(8'h88, 8'h00, RESP_SLVERR);
    wr(8'h88, 8'h5A, RESP_SLVERR);
    $display("test_reset done");
  endtask

  task automatic test_buffer();
    wr(ad(0, REG_A_LO), 8'h34, RESP_OKAY);
    wr(ad(0, REG_A_HI), 8'h12, RESP_OKAY);
    rd(ad(0, REG_A_HI), 8'h12, RESP_OKAY);
    rd(ad(0, REG_A_LO), 8'h34, RESP_OKAY);
    wr(ad(1, REG_A_LO), 8'hAB, RESP_OKAY);
    wr(ad(1, REG_A_HI), 8'hFF, RESP_OKAY);
    rd(ad(1, REG_A_HI), 8'h03, RESP_OKAY);
    rd(ad(1, REG_A_LO), 8'hAB, RESP_OKAY);
    $display("test_buffer done");
  endtask

  task automatic test_count();
    wr(ad(0, REG_A_LO), 8'h05, RESP_OKAY);
    wr(ad(0, REG_A_HI), 8'h00, RESP_OKAY);
    wr(ADDR_MASK, 8'h01, RESP_OKAY);
    wr(ad(0, REG_CTRL1), {2'(MODE_CMP), IO_TOGGLE, 4'h1}, RESP_OKAY);
    wr(ad(0, REG_CTRL0), {1'b0, CK_RISE, 4'h8}, RESP_OKAY);
    u_pins.pulse(1'b0, 0, 3);
    rd(ad(0, REG_CNT_HI), 8'h00, RESP_OKAY);
    rd(ad(0, REG_CNT_LO), 8'h03, RESP_OKAY);
    chk(32'(timer_output_pin_out[0]), 32'h0);
    u_pins.pulse(1'b0, 0, 3);
    chk({timer_output_pin_out[0], timer_output_inverted_pin_out[0], irq_out}, 32'h5);
    rd(ADDR_STATUS, 8'h03, RESP_OKAY);
    rd(ADDR_STATUS, 8'h00, RESP_OKAY);
    chk(32'(irq_out), 32'h0);
    $display("test_count done");
  endtask

  task automatic test_fall();
    wr(ad(1, REG_P_LO), 8'h01, RESP_OKAY);
    wr(ad(1, REG_P_HI), 8'h00, RESP_OKAY);
    wr(ad(1, REG_CTRL0), {1'b0, CK_FALL, 4'h8}, RESP_OKAY);
    u_pins.pulse(1'b0, 1, 3);
    rd(ad(1, REG_CNT_HI), 8'h00, RESP_OKAY);
    rd(ad(1, REG_CNT_LO), 8'h01, RESP_OKAY);
    chk(32'(irq_out), 32'h0);
    wr(ad(2, REG_CTRL1), 8'hB1, RESP_OKAY);
    wr(ad(2, REG_CTRL0), 8'h68, RESP_OKAY);
    u_pins.pulse(1'b0, 2, 1);
    chk(32'(timer_output_pin_out[2]), 32'h1);
    rd(ADDR_STATUS, 8'h08, RESP_OKAY);
    $display("test_fall done");
  endtask

  task automatic test_capture();
    wr(ad(0, REG_CTRL0), 8'h60, RESP_OKAY);
    wr(ad(0, REG_CTRL1), {2'(MODE_CAP), CAP_FALL, 4'h1}, RESP_OKAY);
    wr(ad(0, REG_CTRL0), {1'b0, CK_RISE, 4'h8}, RESP_OKAY);
    u_pins.pulse(1'b0, 0, 4);
    u_pins.pulse(1'b1, 0, 1);
    rd(ad(0, REG_A_HI), 8'h00, RESP_OKAY);
    rd(ad(0, REG_A_LO), 8'h04, RESP_OKAY);
    chk(32'(irq_out), 32'h1);
    rd(ADDR_STATUS, 8'h03, RESP_OKAY);
    wr(ad(1, REG_CTRL1), 8'h40, RESP_OKAY);
    u_pins.pulse(1'b0, 1, 1);
    rd(ad(1, REG_A_HI), 8'h00, RESP_OKAY);
    rd(ad(1, REG_A_LO), 8'h01, RESP_OKAY);
    rd(ADDR_STATUS, 8'h0C, RESP_OKAY);
    $display("test_capture done");
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    give_verdict();
  end

  initial begin
    {bad_count, checks} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'h1;
    rst_b_in = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    test_reset();
    test_buffer();
    test_count();
    test_fall();
    test_capture();
    give_verdict();
  end
endmodule

// *** rtl/tmc_pkg.sv ***
// constants, encodings and register map of the timer module common core
// How it works
// - each counter's clock comes from the clock select field of its first control register.
// - the choices are the system clock divided, the high clock divided, the sub clock or the pin.
// - a counter equal to a comparator raises an event, may clear the counter and move the pin.
// - every timer has two event sources, one for comparator A and one for comparator P.
// - software picks the rising or the falling edge of the timer clock pin.
// - in single pulse mode the timer clock pin also acts as the trigger.
// - the capture pin captures on rising, falling or both edges as the pin function field says.
// - a periodic timer in capture mode also captures from its periodic clock pin.
// - in compare output mode a comparator A match drives the output pins low, high or toggles them.
// - the PWM waveform appears on the same output pins.
// - the standard counter is 16 bits, the three periodic counters are 10 bits.
// - high bytes are direct, low bytes pass through one 8-bit buffer moved by high byte access.
// - a low compare write fills the buffer, the high write stores both bytes at once.
// - a high byte read returns the high byte and snapshots the low byte into the buffer.
package tmc_pkg;
  localparam int N_TMR = 4;
  localparam int STD_W = 16;
  localparam int PER_W = 10;
  localparam logic [15:0] STD_MASK = 16'hFFFF;
  localparam logic [15:0] PER_MASK = 16'h03FF;
  localparam int SYS_HZ = 100_000_000;
  localparam int SUB_HZ = 32_768;
  localparam int SUB_DIV = SYS_HZ / SUB_HZ;
  localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);
  localparam int PRE_W = 6;
  localparam int ADDR_W = 8;
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_A_LO = 3'h4;
  localparam logic [2:0] REG_A_HI = 3'h5;
  localparam logic [2:0] REG_P_LO = 3'h6;
  localparam logic [2:0] REG_P_HI = 3'h7;
  localparam logic [7:0] ADDR_STATUS = 8'h80;
  localparam logic [7:0] ADDR_MASK = 8'h84;
  localparam logic [7:0] C0_MASK = 8'hF8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int C0_PAU = 7;
  localparam int C0_CK_HI = 6;
  localparam int C0_CK_LO = 4;
  localparam int C0_ON = 3;
  localparam int C1_MD_HI = 7;
  localparam int C1_MD_LO = 6;
  localparam int C1_IO_HI = 5;
  localparam int C1_IO_LO = 4;
  localparam int C1_OC = 3;
  localparam int C1_CCLR = 0;
  typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} tmc_mode_t;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_RISE = 3'h6;
  localparam logic [2:0] CK_FALL = 3'h7;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] IO_INACT = 2'h0;
  localparam logic [1:0] IO_ACT = 2'h1;
  localparam logic [1:0] IO_PWM = 2'h2;
  localparam logic [1:0] IO_SINGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAP_OFF = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/tmc_timer.sv ***
// one timer channel: counter, comparators, capture and output pins
`timescale 1ns/100ps
module tmc_timer #(
  parameter int WIDTH    = 16,
  parameter bit PERIODIC = 1'b0
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [5:0]  div_tick_in,
  input  wire logic [7:0]  ctrl0_in,
  input  wire logic [7:0]  ctrl1_in,
  input  wire logic [15:0] cmpa_in,
  input  wire logic [15:0] cmpp_in,
  input  wire logic        clk_pin_in,
  input  wire logic        cap_pin_in,
  output logic      [15:0] count_out,
  output logic      [15:0] cap_val_out,
  output logic             match_a_out,
  output logic             match_p_out,
  output logic             capture_out,
  output logic             pin_out,
  output logic             pin_inv_out
);
  import tmc_pkg::*;
  logic [WIDTH-1:0] cnt_ff;
  logic [15:0]      cap_ff;
  logic             on_q_ff;
  logic             ck_q_ff;
  logic             cp_q_ff;
  logic             pulse_ff;
  logic             ma_ff;
  logic             mp_ff;
  logic             capt_ff;
  logic             pin_ff;
  logic             pin_n_ff;
  logic             nxt_pin;
  logic             src;
  tmc_mode_t        mode;
  logic [1:0]       io;
  logic             on;
  logic             run;
  logic             tick;
  logic             hit_a;
  logic             hit_p;
  logic             clr_hit;
  logic             on_rise;
  logic             ck_rise;
  logic             ck_fall;
  logic             cp_rise;
  logic             cp_fall;
  logic             cap_ev;
  logic             trig;

  assign mode    = tmc_mode_t'(ctrl1_in[C1_MD_HI:C1_MD_LO]);
  assign io      = ctrl1_in[C1_IO_HI:C1_IO_LO];
  assign on      = ctrl0_in[C0_ON];
  assign on_rise = on & ~on_q_ff;
  assign ck_rise = clk_pin_in & ~ck_q_ff;
  assign ck_fall = ~clk_pin_in & ck_q_ff;
  assign cp_rise = cap_pin_in & ~cp_q_ff;
  assign cp_fall = ~cap_pin_in & cp_q_ff;

  always_comb begin
    case (ctrl0_in[C0_CK_HI:C0_CK_LO])
      CK_SYS4: src = div_tick_in[0];
      CK_SYS:  src = div_tick_in[1];
      CK_H16:  src = div_tick_in[2];
      CK_H64:  src = div_tick_in[3];
      CK_SUB0: src = div_tick_in[4];
      CK_SUB1: src = div_tick_in[5];
      CK_RISE: src = ck_rise;
      CK_FALL: src = ck_fall;
      default: src = 1'b0;
    endcase
  end

  // single pulse counts only while the pulse is out, so a trigger restarts a clean period
  assign run     = on & ~ctrl0_in[C0_PAU] & (mode != MODE_PWM || io != IO_SINGLE || pulse_ff);
  assign tick    = run & src;
  assign hit_a   = tick & (cnt_ff == cmpa_in[WIDTH-1:0]);
  assign hit_p   = tick & (cnt_ff == cmpp_in[WIDTH-1:0]);
  assign clr_hit = ctrl1_in[C1_CCLR] ? hit_a : hit_p;
  assign trig    = on & (mode == MODE_PWM) & (io == IO_SINGLE) & ck_rise;
  assign cap_ev  = on & (mode == MODE_CAP) & (io != CAP_OFF) &
                   (((io == CAP_RISE || io == CAP_BOTH) & cp_rise) |
                    ((io == CAP_FALL || io == CAP_BOTH) & cp_fall) |
                    (PERIODIC & ck_rise));

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      on_q_ff <= 1'b0;
      ck_q_ff <= 1'b0;
      cp_q_ff <= 1'b0;
    end else begin
      on_q_ff <= on;
      ck_q_ff <= clk_pin_in;
      cp_q_ff <= cap_pin_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
    end else if (on_rise) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= clr_hit ? '0 : cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ma_ff   <= 1'b0;
      mp_ff   <= 1'b0;
      capt_ff <= 1'b0;
      cap_ff  <= 16'h0000;
    end else begin
      ma_ff   <= (mode == MODE_CAP) ? cap_ev : hit_a;
      mp_ff   <= hit_p;
      capt_ff <= cap_ev;
      if (cap_ev) begin
        cap_ff <= 16'(cnt_ff);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || on_rise) begin
      pulse_ff <= 1'b0;
    end else if (trig) begin
      pulse_ff <= 1'b1;
    end else if (hit_a || hit_p) begin
      pulse_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_pin = pin_ff;
    if (on_rise) begin
      nxt_pin = ctrl1_in[C1_OC];
    end else begin
      case (mode)
        MODE_CMP: begin
          if (hit_a && io == IO_LOW) nxt_pin = 1'b0;
          if (hit_a && io == IO_HIGH) nxt_pin = 1'b1;
          if (hit_a && io == IO_TOGGLE) nxt_pin = ~pin_ff;
        end
        MODE_PWM: begin
          case (io)
            IO_INACT: nxt_pin = ctrl1_in[C1_OC];
            IO_ACT:   nxt_pin = ~ctrl1_in[C1_OC];
            IO_PWM: begin
              if (clr_hit) nxt_pin = ~ctrl1_in[C1_OC];
              if (hit_a) nxt_pin = ctrl1_in[C1_OC];
            end
            default: begin
              if (trig) nxt_pin = ~ctrl1_in[C1_OC];
              if (hit_a) nxt_pin = ctrl1_in[C1_OC];
            end
          endcase
        end
        default: nxt_pin = pin_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pin_ff   <= 1'b0;
      pin_n_ff <= 1'b1;
    end else begin
      pin_ff   <= nxt_pin;
      pin_n_ff <= ~nxt_pin;
    end
  end

  assign count_out   = 16'(cnt_ff);
  assign cap_val_out = cap_ff;
  assign match_a_out = ma_ff;
  assign match_p_out = mp_ff;
  assign capture_out = capt_ff;
  assign pin_out     = pin_ff;
  assign pin_inv_out = pin_n_ff;
endmodule

// *** rtl/tmc_top.sv ***
// timer core top: AXI4-Lite registers, prescalers, byte buffers, interrupts, four timers
`timescale 1ns/100ps
module tmc_top (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_b_in,
  input  wire logic [tmc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                       s_axi_awvalid_in,
  output logic                            s_axi_awready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  input  wire logic                       s_axi_wvalid_in,
  output logic                            s_axi_wready_out,
  output logic      [1:0]                 s_axi_bresp_out,
  output logic                            s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  input  wire logic [tmc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                       s_axi_arvalid_in,
  output logic                            s_axi_arready_out,
  output logic      [31:0]                s_axi_rdata_out,
  output logic      [1:0]                 s_axi_rresp_out,
  output logic                            s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in,
  input  wire logic [tmc_pkg::N_TMR-1:0]  timer_clock_pin_in,
  input  wire logic [tmc_pkg::N_TMR-1:0]  capture_input_pin_in,
  output logic      [tmc_pkg::N_TMR-1:0]  timer_output_pin_out,
  output logic      [1:0]                 timer_output_inverted_pin_out,
  output logic                            irq_out
);
  import tmc_pkg::*;

  logic             awready_ff;
  logic             wready_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             arready_ff;
  logic             rvalid_ff;
  logic [1:0]       rresp_ff;
  logic [31:0]      rdata_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [11:0]      sub_ff;
  logic [5:0]       div_ff;
  logic [7:0]       status_ff;
  logic [7:0]       mask_ff;
  logic [7:0]       nxt_status;
  logic             irq_ff;
  logic [7:0]       events;

  logic [7:0]       ctrl0_ff [N_TMR];
  logic [7:0]       ctrl1_ff [N_TMR];
  logic [15:0]      cmpa_ff  [N_TMR];
  logic [15:0]      cmpp_ff  [N_TMR];
  logic [7:0]       buf_ff   [N_TMR];
  logic [15:0]      count    [N_TMR];
  logic [15:0]      cap_val  [N_TMR];
  logic [N_TMR-1:0] match_a;
  logic [N_TMR-1:0] match_p;
  logic [N_TMR-1:0] capture;
  logic [N_TMR-1:0] pin;
  logic [N_TMR-1:0] pin_inv;

  logic             wr_hs;
  logic             rd_hs;
  logic             wr_tmr_ok;
  logic             rd_tmr_ok;
  logic             wr_ok;
  logic             rd_ok;
  logic [1:0]       wr_t;
  logic [2:0]       wr_r;
  logic [1:0]       rd_t;
  logic [2:0]       rd_r;
  logic             wr_en;
  logic [7:0]       wr_byte;
  logic             rd_status;
  logic [7:0]       rd_byte;

  // write address and data are taken together in one beat
  assign wr_hs     = s_axi_awvalid_in & awready_ff;
  assign rd_hs     = s_axi_arvalid_in & arready_ff;
  assign wr_tmr_ok = ~s_axi_awaddr_in[7];
  assign rd_tmr_ok = ~s_axi_araddr_in[7];
  assign wr_ok     = wr_tmr_ok | (s_axi_awaddr_in == ADDR_STATUS) |
                     (s_axi_awaddr_in == ADDR_MASK);
  assign rd_ok     = rd_tmr_ok | (s_axi_araddr_in == ADDR_STATUS) |
                     (s_axi_araddr_in == ADDR_MASK);
  assign wr_t      = s_axi_awaddr_in[6:5];
  assign wr_r      = s_axi_awaddr_in[4:2];
  assign rd_t      = s_axi_araddr_in[6:5];
  assign rd_r      = s_axi_araddr_in[4:2];
  // only the low lane carries a register byte, other lanes are dropped
  assign wr_en     = wr_hs & s_axi_wstrb_in[0];
  assign wr_byte   = s_axi_wdata_in[7:0];
  assign rd_status = rd_hs & (s_axi_araddr_in == ADDR_STATUS);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      awready_ff <= ~awready_ff & s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_ff;
      wready_ff  <= ~awready_ff & s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_ff;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_hs) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      arready_ff <= 1'b0;
    end else begin
      arready_ff <= ~arready_ff & s_axi_arvalid_in & ~rvalid_ff;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (!rd_tmr_ok) begin
      if (s_axi_araddr_in == ADDR_STATUS) rd_byte = status_ff;
      if (s_axi_araddr_in == ADDR_MASK) rd_byte = mask_ff;
    end else begin
      case (rd_r)
        REG_CTRL0:  rd_byte = ctrl0_ff[rd_t] & C0_MASK;
        REG_CTRL1:  rd_byte = ctrl1_ff[rd_t];
        REG_CNT_LO: rd_byte = buf_ff[rd_t];
        REG_CNT_HI: rd_byte = count[rd_t][15:8];
        REG_A_LO:   rd_byte = buf_ff[rd_t];
        REG_A_HI:   rd_byte = cmpa_ff[rd_t][15:8];
        REG_P_LO:   rd_byte = buf_ff[rd_t];
        REG_P_HI:   rd_byte = cmpp_ff[rd_t][15:8];
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_hs) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // one shared prescaler keeps the divided system ticks phase aligned, the sub ticks run from sub_ff
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pre_ff <= '0;
      sub_ff <= 12'h000;
    end else begin
      pre_ff <= pre_ff + 1'b1;
      sub_ff <= (sub_ff == SUB_LAST) ? 12'h000 : sub_ff + 12'h001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      div_ff <= 6'h00;
    end else begin
      div_ff[0] <= (pre_ff[1:0] == 2'h3);
      div_ff[1] <= 1'b1;
      div_ff[2] <= (pre_ff[3:0] == 4'hF);
      div_ff[3] <= (pre_ff == 6'h3F);
      div_ff[4] <= (sub_ff == SUB_LAST);
      div_ff[5] <= (sub_ff == SUB_LAST);
    end
  end

  generate
    for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
      localparam int W = (i == 0) ? STD_W : PER_W;
      localparam logic [15:0] MSK = (i == 0) ? STD_MASK : PER_MASK;
      logic wsel;
      logic rsel;
      assign wsel = wr_en & wr_tmr_ok & (wr_t == 2'(i));
      assign rsel = rd_hs & rd_tmr_ok & (rd_t == 2'(i));

      always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
          ctrl0_ff[i] <= CTRL_RST;
          ctrl1_ff[i] <= CTRL_RST;
        end else if (wsel && wr_r == REG_CTRL0) begin
          ctrl0_ff[i] <= wr_byte & C0_MASK;
        end else if (wsel && wr_r == REG_CTRL1) begin
          ctrl1_ff[i] <= wr_byte;
        end
      end

      // a write landing with a high byte read keeps the written byte
      always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
          buf_ff[i] <= 8'h00;
        end else if (wsel && (wr_r == REG_A_LO || wr_r == REG_P_LO)) begin
          buf_ff[i] <= wr_byte;
        end else if (rsel && rd_r == REG_CNT_HI) begin
          buf_ff[i] <= count[i][7:0];
        end else if (rsel && rd_r == REG_A_HI) begin
          buf_ff[i] <= cmpa_ff[i][7:0];
        end else if (rsel && rd_r == REG_P_HI) begin
          buf_ff[i] <= cmpp_ff[i][7:0];
        end
      end

      // capture beats a same-cycle software write so no captured count is lost
      always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
          cmpa_ff[i] <= 16'h0000;
        end else if (capture[i]) begin
          cmpa_ff[i] <= cap_val[i] & MSK;
        end else if (wsel && wr_r == REG_A_HI) begin
          cmpa_ff[i] <= {wr_byte, buf_ff[i]} & MSK;
        end
      end

      always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
          cmpp_ff[i] <= 16'h0000;
        end else if (wsel && wr_r == REG_P_HI) begin
          cmpp_ff[i] <= {wr_byte, buf_ff[i]} & MSK;
        end
      end

      tmc_timer #(
        .WIDTH    (W),
        .PERIODIC (i != 0)
      ) u_tmr (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .div_tick_in (div_ff),
        .ctrl0_in    (ctrl0_ff[i]),
        .ctrl1_in    (ctrl1_ff[i]),
        .cmpa_in     (cmpa_ff[i]),
        .cmpp_in     (cmpp_ff[i]),
        .clk_pin_in  (timer_clock_pin_in[i]),
        .cap_pin_in  (capture_input_pin_in[i]),
        .count_out   (count[i]),
        .cap_val_out (cap_val[i]),
        .match_a_out (match_a[i]),
        .match_p_out (match_p[i]),
        .capture_out (capture[i]),
        .pin_out     (pin[i]),
        .pin_inv_out (pin_inv[i])
      );

      assign events[2*i]   = match_a[i];
      assign events[2*i+1] = match_p[i];
    end
  endgenerate

  // a new event in the clearing read still sets its bit
  assign nxt_status = (rd_status ? 8'h00 : status_ff) | events;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      status_ff <= 8'h00;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask_ff);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      mask_ff <= 8'h00;
    end else if (wr_en && s_axi_awaddr_in == ADDR_MASK) begin
      mask_ff <= wr_byte;
    end
  end

  assign s_axi_awready_out             = awready_ff;
  assign s_axi_wready_out              = wready_ff;
  assign s_axi_bvalid_out              = bvalid_ff;
  assign s_axi_bresp_out               = bresp_ff;
  assign s_axi_arready_out             = arready_ff;
  assign s_axi_rvalid_out              = rvalid_ff;
  assign s_axi_rresp_out               = rresp_ff;
  assign s_axi_rdata_out               = rdata_ff;
  assign timer_output_pin_out          = pin;
  assign timer_output_inverted_pin_out = pin_inv[1:0];
  assign irq_out                       = irq_ff;
endmodule
